//--- dcwa_checker.sv
// Port-level assertions for the command word assembler.
// Assumes binding into dcwa_top; bind follows the module.
`timescale 1ns/1ns
module dcwa_checker (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        ce,
	input wire logic        pt_wr,
	input wire logic        pt_rd,
	input wire logic [7:0]  pt_addr,
	input wire logic [15:0] pt_wdata,
	input wire logic        pt_rvalid,
	input wire logic [14:0] max_speed,
	input wire logic [15:0] drv_cmd_word,
	input wire logic        drv_cmd_load,
	input wire logic [14:0] drv_speed,
	input wire logic        stop_pulse,
	input wire logic        start_pulse,
	input wire logic        clear_pulse,
	input wire logic        jog_req,
	input wire logic        local_req,
	input wire logic        mop_inc,
	input wire logic        mop_dec
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// Assertions
	chk_load_on_high: assert property (pt_wr && ce &&
		pt_addr == 8'h5a |=> drv_cmd_load)
		else $error("no load after high point write");
	chk_high_byte: assert property (pt_wr && ce &&
		pt_addr == 8'h5a |=>
		drv_cmd_word[15:8] == $past(pt_wdata[7:0]))
		else $error("high byte of word wrong");
	chk_read_answer: assert property (pt_rd && ce |=> pt_rvalid)
		else $error("read not answered");
	chk_start_cause: assert property (start_pulse |->
		$past(drv_cmd_load, 2) && $past(drv_cmd_word[1], 2) &&
		!$past(drv_cmd_word[0], 2))
		else $error("start pulse without cause");
	chk_stop_cause: assert property (stop_pulse |->
		$past(drv_cmd_load, 2) && $past(drv_cmd_word[0], 2))
		else $error("stop pulse without cause");
	chk_clear_once: assert property (clear_pulse |->
		$past(drv_cmd_word[3], 2) ##1 !clear_pulse)
		else $error("clear pulse wrong");
	chk_level_bits: assert property (drv_cmd_load |-> ##2
		{mop_dec, mop_inc, local_req, jog_req} ==
		$past({drv_cmd_word[15], drv_cmd_word[7:6],
		drv_cmd_word[2]}, 2))
		else $error("level requests differ from word");
	chk_speed_clamp: assert property (drv_speed <= max_speed)
		else $error("speed above maximum");
endmodule // dcwa_checker

bind dcwa_top dcwa_checker u_chk (.*);

//--- dcwa_drive_model.sv
// Drive stand-in: reports the last forwarded command word as its status.
// Assumes drv_cmd_load marks each word forwarded by the assembler.
`timescale 1ns/1ns
module dcwa_drive_model #(
	parameter logic [14:0] FBK = 15'h1234
) (
	input  wire logic        clk_sys,
	input  wire logic [15:0] drv_cmd_word,
	input  wire logic        drv_cmd_load,
	output var  logic [15:0] drv_status,
	output wire logic [14:0] drv_fbk
);
	assign drv_fbk = FBK;
	initial drv_status = 16'h0000;
	always @(posedge clk_sys) begin
		if (drv_cmd_load)
			drv_status <= drv_cmd_word;
	end
endmodule // dcwa_drive_model

//--- dcwa_regs.vh
// Constants for the drive command word assembler: point numbers, fields,
// reset values and timing counts.
// Assumes inclusion by bare name from the scale and top design files.
`ifndef DCWA_REGS_VH
`define DCWA_REGS_VH

// =========================================================
// Point numbers (register offsets)
`define DCWA_PT_CMD_LO      8'h59
`define DCWA_PT_CMD_HI      8'h5a
`define DCWA_PT_STS_LO      8'h5f
`define DCWA_PT_STS_HI      8'h60
`define DCWA_PT_FEEDBACK    8'h5b
`define DCWA_PT_REFERENCE   8'h5c
`define DCWA_PT_RUN_STOP    8'h18
`define DCWA_PT_RUN_ENABLE  8'h1a
`define DCWA_PT_FLT_CLEAR   8'h5e
`define DCWA_PT_DIRECTION   8'h16

// =========================================================
// Command word fields
`define DCWA_B_STOP         0
`define DCWA_B_START        1
`define DCWA_B_JOG          2
`define DCWA_B_CLR          3
`define DCWA_F_DIR_LO       4
`define DCWA_F_DIR_HI       5
`define DCWA_B_LOCAL        6
`define DCWA_B_MOP_INC      7
`define DCWA_F_ACC_LO       8
`define DCWA_F_ACC_HI       9
`define DCWA_F_DEC_LO       10
`define DCWA_F_DEC_HI       11
`define DCWA_F_REF_LO       12
`define DCWA_F_REF_HI       14
`define DCWA_B_MOP_DEC      15

// =========================================================
// Reset values and scaling
`define DCWA_CMD_RST        16'h0000
`define DCWA_FULL_SCALE     15'h7fff
`define DCWA_MAXSPD_RST     15'h7fff

// =========================================================
// Timing: momentary stop pulse width
`define DCWA_STOP_PULSE_NS  80
`define DCWA_CLK_NS         8
// Cycle count of the stop pulse, sized for the 4-bit counter
`define DCWA_STOP_PULSE_CYC 4'ha

`endif

//--- dcwa_scale.v
// Speed scaling: reference clamp against maximum speed, feedback pass.
// Assumes both values use the same 15-bit full scale of maximum frequency.
`timescale 1ns/1ns
`include "dcwa_regs.vh"
module dcwa_scale (
	ref_in,
	max_speed,
	fbk_in,
	speed_out,
	fbk_out
);
	input  wire [14:0] ref_in;
	input  wire [14:0] max_speed;
	input  wire [14:0] fbk_in;
	output wire [14:0] speed_out;
	output wire [14:0] fbk_out;

	// Both share full scale 32767 = maximum frequency
	assign speed_out = (ref_in > max_speed) ? max_speed : ref_in;
	assign fbk_out   = (fbk_in > `DCWA_FULL_SCALE) ?
		`DCWA_FULL_SCALE : fbk_in;
endmodule // dcwa_scale

//--- dcwa_sync.v
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes clk_sys and synchronous active-low nrst.
`timescale 1ns/1ns
module dcwa_sync (
	clk_sys,
	nrst,
	ce,
	din,
	dout
);
	input  wire clk_sys;
	input  wire nrst;
	input  wire ce;
	input  wire din;
	output wire dout;

	reg meta_ff;
	reg sync_ff;

	always @(posedge clk_sys) begin
		if (!nrst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else if (ce) begin
			meta_ff <= din;
			sync_ff <= meta_ff;
		end
	end

	assign dout = sync_ff;
endmodule // dcwa_sync

//--- dcwa_top.v
// Drive command word assembler: point writes from the network master,
// command word assembly, field decode and edge-qualified commands.
// Assumes point access strobes are synchronous to clk_sys; drive-side
// status and feedback arrive as raw levels and are synchronised here.
`timescale 1ns/1ns
`include "dcwa_regs.vh"

// Contract
// - Low and high 8-bit points join into 16-bit word, low is bits 0-7.
// - Point writes update buffer; word forwarded to drive on high write.
// - Speed reference keeps only its lower 15 bits, unsigned.
// - 32767 is maximum frequency; speed clamped to maximum speed.
// - Feedback uses same full scale as reference.
// - Run/stop set to stop pulses bit 0 high, then back to 0.
// - Start acts only if bit 0 was previously 0.
// - Start, stop, clear faults act only on 0 to 1 transition.
// - Bit 2 requests jog; bit 3 requests fault clear.
// - Bits 5:4 direction: none, forward, reverse, hold.
// - Bit 6 requests local control; bit 7 increments motor pot.
// - Bits 9:8 accel rate: none, rate 1, rate 2, hold.
// - Bits 11:10 decel rate: none, rate 1, rate 2, hold.
// - Bits 14:12 select reference 1 to 7, 000 none.
// - Outputs flow master to adapter; status flows adapter to master.
// - Run point starts drive; run or enable point at stop stops it.
// - Status low refreshed only on status high read.
module dcwa_top (
	clk_sys,
	nrst,
	ce,
	pt_wr,
	pt_rd,
	pt_addr,
	pt_wdata,
	pt_rdata,
	pt_rvalid,
	max_speed,
	drv_status,
	drv_fbk,
	drv_cmd_word,
	drv_cmd_load,
	drv_speed,
	stop_pulse,
	start_pulse,
	clear_pulse,
	jog_req,
	dir_fwd,
	dir_rev,
	local_req,
	mop_inc,
	mop_dec,
	acc_rate,
	dec_rate,
	ref_sel
);
	input  wire        clk_sys;
	input  wire        nrst;
	input  wire        ce;
	input  wire        pt_wr;
	input  wire        pt_rd;
	input  wire [7:0]  pt_addr;
	input  wire [15:0] pt_wdata;
	output reg  [15:0] pt_rdata;
	output reg         pt_rvalid;
	input  wire [14:0] max_speed;
	input  wire [15:0] drv_status;
	input  wire [14:0] drv_fbk;
	output reg  [15:0] drv_cmd_word;
	output reg         drv_cmd_load;
	output reg  [14:0] drv_speed;
	output reg         stop_pulse;
	output reg         start_pulse;
	output reg         clear_pulse;
	output reg         jog_req;
	output reg         dir_fwd;
	output reg         dir_rev;
	output reg         local_req;
	output reg         mop_inc;
	output reg         mop_dec;
	output reg  [1:0]  acc_rate;
	output reg  [1:0]  dec_rate;
	output reg  [2:0]  ref_sel;

	// =========================================================
	// Functions
	function [1:0] rate_dec;
		input [1:0] code;
		input [1:0] cur;
		begin
			case (code)
			2'h1:    rate_dec = 2'h1;
			2'h2:    rate_dec = 2'h2;
			default: rate_dec = cur;
			endcase
		end
	endfunction

	function hit;
		input [7:0] a;
		input [7:0] pt;
		begin
			hit = (a == pt);
		end
	endfunction

	// =========================================================
	// Synchronise drive-side levels
	wire [15:0] sts_sync;
	wire [14:0] fbk_sync;
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_sts
			dcwa_sync u_s (
				.clk_sys (clk_sys),
				.nrst    (nrst),
				.ce      (ce),
				.din     (drv_status[gi]),
				.dout    (sts_sync[gi])
			);
		end
		for (gi = 0; gi < 15; gi = gi + 1) begin : g_fbk
			dcwa_sync u_f (
				.clk_sys (clk_sys),
				.nrst    (nrst),
				.ce      (ce),
				.din     (drv_fbk[gi]),
				.dout    (fbk_sync[gi])
			);
		end
	endgenerate

	// =========================================================
	// Point registers
	reg  [7:0]  cmd_lo_ff;
	reg  [7:0]  cmd_hi_ff;
	reg  [14:0] ref_ff;
	reg  [7:0]  sts_lo_ff;
	reg  [15:0] prev_word_ff;
	reg  [3:0]  stop_cnt_ff;
	reg         run_pt_ff;
	reg         en_pt_ff;
	reg         drv_cmd_load_d;
	wire [14:0] speed_w;
	wire [14:0] fbk_w;

	wire wr_lo  = pt_wr & hit(pt_addr, `DCWA_PT_CMD_LO);
	wire wr_hi  = pt_wr & hit(pt_addr, `DCWA_PT_CMD_HI);
	wire wr_ref = pt_wr & hit(pt_addr, `DCWA_PT_REFERENCE);
	wire wr_run = pt_wr & hit(pt_addr, `DCWA_PT_RUN_STOP);
	wire wr_en  = pt_wr & hit(pt_addr, `DCWA_PT_RUN_ENABLE);
	wire wr_clr = pt_wr & hit(pt_addr, `DCWA_PT_FLT_CLEAR);
	wire wr_dir = pt_wr & hit(pt_addr, `DCWA_PT_DIRECTION);
	wire rd_shi = pt_rd & hit(pt_addr, `DCWA_PT_STS_HI);

	// Word about to be forwarded; digital points patch the last forwarded word
	reg  [15:0] nxt_word;
	reg         nxt_load;
	reg  [3:0]  nxt_stop_cnt;
	always @* begin
		nxt_word     = drv_cmd_word;
		nxt_load     = 1'b0;
		nxt_stop_cnt = (stop_cnt_ff != 4'h0) ? stop_cnt_ff - 4'h1 : 4'h0;
		// Pulse end first, so a stop written in the same cycle wins
		if (stop_cnt_ff == 4'h1) begin
			nxt_word[`DCWA_B_STOP] = 1'b0;
			nxt_load = 1'b1;
		end
		if (wr_hi) begin
			nxt_word = {pt_wdata[7:0], cmd_lo_ff};
			nxt_load = 1'b1;
		end
		if (wr_run && pt_wdata[0]) begin
			nxt_word[`DCWA_B_STOP]  = 1'b0;
			nxt_word[`DCWA_B_START] = 1'b1;
			nxt_load = 1'b1;
		end
		if ((wr_run && !pt_wdata[0]) || (wr_en && !pt_wdata[0])) begin
			nxt_word[`DCWA_B_STOP]  = 1'b1;
			nxt_word[`DCWA_B_START] = 1'b0;
			nxt_stop_cnt = `DCWA_STOP_PULSE_CYC;
			nxt_load = 1'b1;
		end
		if (wr_clr) begin
			nxt_word[`DCWA_B_CLR] = pt_wdata[0];
			nxt_load = 1'b1;
		end
		if (wr_dir) begin
			nxt_word[`DCWA_F_DIR_HI:`DCWA_F_DIR_LO] = pt_wdata[0] ?
				2'h2 : 2'h1;
			nxt_load = 1'b1;
		end
	end

	always @(posedge clk_sys) begin
		if (!nrst) begin
			cmd_lo_ff    <= 8'h00;
			cmd_hi_ff    <= 8'h00;
			ref_ff       <= 15'h0000;
			sts_lo_ff    <= 8'h00;
			drv_cmd_word <= `DCWA_CMD_RST;
			drv_cmd_load <= 1'b0;
			prev_word_ff <= `DCWA_CMD_RST;
			stop_cnt_ff  <= 4'h0;
			run_pt_ff    <= 1'b0;
			en_pt_ff     <= 1'b0;
			pt_rdata     <= 16'h0000;
			pt_rvalid    <= 1'b0;
			drv_speed    <= 15'h0000;
		end else if (ce) begin
			if (wr_lo)
				cmd_lo_ff <= pt_wdata[7:0];
			if (wr_hi)
				cmd_hi_ff <= pt_wdata[7:0];
			if (wr_ref)
				ref_ff <= pt_wdata[14:0];
			if (wr_run)
				run_pt_ff <= pt_wdata[0];
			if (wr_en)
				en_pt_ff <= pt_wdata[0];
			drv_cmd_word <= nxt_word;
			drv_cmd_load <= nxt_load;
			stop_cnt_ff  <= nxt_stop_cnt;
			if (nxt_load)
				prev_word_ff <= drv_cmd_word;
			drv_speed <= speed_w;
			// Status flows toward the master; low half latched on high read
			if (rd_shi) begin
				sts_lo_ff <= sts_sync[7:0];
			end
			pt_rvalid <= pt_rd;
			pt_rdata  <= 16'h0000;
			if (pt_rd) begin
				case (pt_addr)
				`DCWA_PT_CMD_LO:    pt_rdata <= {8'h00, cmd_lo_ff};
				`DCWA_PT_CMD_HI:    pt_rdata <= {8'h00, cmd_hi_ff};
				`DCWA_PT_REFERENCE: pt_rdata <= {1'b0, ref_ff};
				`DCWA_PT_FEEDBACK:  pt_rdata <= {1'b0, fbk_w};
				`DCWA_PT_STS_LO:    pt_rdata <= {8'h00, sts_lo_ff};
				`DCWA_PT_STS_HI:    pt_rdata <= {8'h00, sts_sync[15:8]};
				`DCWA_PT_RUN_STOP:  pt_rdata <= {15'h0000, run_pt_ff};
				`DCWA_PT_RUN_ENABLE: pt_rdata <= {15'h0000, en_pt_ff};
				default:            pt_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// =========================================================
	// Scaling
	dcwa_scale u_scale (
		.ref_in    (ref_ff),
		.max_speed (max_speed),
		.fbk_in    (fbk_sync),
		.speed_out (speed_w),
		.fbk_out   (fbk_w)
	);

	// =========================================================
	// Field decode of the forwarded word
	wire [15:0] w = drv_cmd_word;
	wire [15:0] p = prev_word_ff;
	always @(posedge clk_sys) begin
		if (!nrst) begin
			stop_pulse  <= 1'b0;
			start_pulse <= 1'b0;
			clear_pulse <= 1'b0;
			jog_req     <= 1'b0;
			dir_fwd     <= 1'b0;
			dir_rev     <= 1'b0;
			local_req   <= 1'b0;
			mop_inc     <= 1'b0;
			mop_dec     <= 1'b0;
			acc_rate    <= 2'h0;
			dec_rate    <= 2'h0;
			ref_sel     <= 3'h0;
		end else if (ce) begin
			stop_pulse  <= drv_cmd_load_d & w[`DCWA_B_STOP] &
				~p[`DCWA_B_STOP];
			start_pulse <= drv_cmd_load_d & w[`DCWA_B_START] &
				~p[`DCWA_B_START] & ~p[`DCWA_B_STOP] &
				~w[`DCWA_B_STOP];
			clear_pulse <= drv_cmd_load_d & w[`DCWA_B_CLR] &
				~p[`DCWA_B_CLR];
			jog_req     <= w[`DCWA_B_JOG];
			case (w[`DCWA_F_DIR_HI:`DCWA_F_DIR_LO])
			2'h1: begin
				dir_fwd <= 1'b1;
				dir_rev <= 1'b0;
			end
			2'h2: begin
				dir_fwd <= 1'b0;
				dir_rev <= 1'b1;
			end
			default: begin
				dir_fwd <= dir_fwd;
				dir_rev <= dir_rev;
			end
			endcase
			local_req <= w[`DCWA_B_LOCAL];
			mop_inc   <= w[`DCWA_B_MOP_INC];
			mop_dec   <= w[`DCWA_B_MOP_DEC];
			acc_rate  <= rate_dec(w[`DCWA_F_ACC_HI:`DCWA_F_ACC_LO],
				acc_rate);
			dec_rate  <= rate_dec(w[`DCWA_F_DEC_HI:`DCWA_F_DEC_LO],
				dec_rate);
			if (w[`DCWA_F_REF_HI:`DCWA_F_REF_LO] != 3'h0)
				ref_sel <= w[`DCWA_F_REF_HI:`DCWA_F_REF_LO];
		end
	end

	always @(posedge clk_sys) begin
		if (!nrst)
			drv_cmd_load_d <= 1'b0;
		else if (ce)
			drv_cmd_load_d <= drv_cmd_load;
	end
endmodule // dcwa_top

//--- dcwa_top_bench.sv
// Self-checking bench for the command word assembler.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ns
module dcwa_top_bench;
	logic        clk_sys = 1'h0, nrst = 1'h0, pt_wr = 1'h0, pt_rd = 1'h0;
	logic [7:0]  pt_addr = 8'h00;
	logic [15:0] pt_wdata = 16'h0000, pt_rdata, drv_status, drv_cmd_word, d;
	logic [14:0] max_speed = 15'h3000, drv_fbk, drv_speed;
	logic        pt_rvalid, drv_cmd_load, stop_pulse, start_pulse;
	logic        clear_pulse, jog_req, dir_fwd, dir_rev, local_req;
	logic        mop_inc, mop_dec, ce = 1'h1;
	logic [1:0]  acc_rate, dec_rate;
	logic [2:0]  ref_sel;
	int          miscompares = 0, n_compared = 0, cyc = 0;

	dcwa_top uut (.*);
	dcwa_drive_model drv (.*);

	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			report_and_stop;
		end
	end
	// ==========================================================
	// Shared tasks
	task report_and_stop;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] v);
		@(negedge clk_sys);
		pt_wr = 1'h1;
		pt_addr = a;
		pt_wdata = v;
		@(negedge clk_sys);
		pt_wr = 1'h0;
	endtask
	task rd(input logic [7:0] a);
		@(negedge clk_sys);
		pt_rd = 1'h1;
		pt_addr = a;
		@(negedge clk_sys);
		pt_rd = 1'h0;
		cmp(pt_rvalid, 16'h0001);
		d = pt_rdata;
	endtask
	// ==========================================================
	// Scenarios
	task t_word;
		wr(8'h59, 16'h00a5);
		repeat (3) begin
			@(negedge clk_sys);
			cmp(drv_cmd_load, 16'h0000);
		end
		wr(8'h5a, 16'h003c);
		cmp(drv_cmd_load, 16'h0001);
		cmp(drv_cmd_word, 16'h3ca5);
		$display("t_word done");
	endtask
	task t_fields;
		logic [1:0] c, ef, ea, ed;
		logic [2:0] er;
		ef = 2'h1;
		ea = 2'h0;
		ed = 2'h0;
		er = 3'h3;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			wr(8'h59, {8'h00, c[0], c[0], c, 1'h0, c[0], 2'h0});
			wr(8'h5a, {8'h00, c[0], 1'h0, c, c, c});
			repeat (2) @(negedge clk_sys);
			if (c == 2'h1)
				ef = 2'h2;
			if (c == 2'h2)
				ef = 2'h1;
			if (c == 2'h1 || c == 2'h2) begin
				ea = c;
				ed = c;
			end
			if (c != 2'h0)
				er = {1'h0, c};
			cmp({dir_fwd, dir_rev}, ef);
			cmp(acc_rate, ea);
			cmp(dec_rate, ed);
			cmp(ref_sel, er);
			cmp({mop_dec, mop_inc, local_req, jog_req}, {4{c[0]}});
		end
		$display("t_fields done");
	endtask
	task t_edges;
		logic [7:0] lo [7] = '{8'h02, 8'h02, 8'h01, 8'h02, 8'h00, 8'h02, 8'h0a};
		logic [2:0] ex [7] = '{3'h1, 3'h0, 3'h2, 3'h0, 3'h0, 3'h1, 3'h4};
		for (int i = 0; i < 7; i++) begin
			wr(8'h59, {8'h00, lo[i]});
			wr(8'h5a, 16'h0000);
			repeat (2) @(negedge clk_sys);
			cmp({clear_pulse, stop_pulse, start_pulse}, ex[i]);
		end
		$display("t_edges done");
	endtask
	task t_run;
		wr(8'h18, 16'h0001);
		cmp(drv_cmd_word[1:0], 16'h0002);
		wr(8'h18, 16'h0000);
		cmp(drv_cmd_word[0], 16'h0001);
		repeat (10) @(negedge clk_sys);
		cmp({drv_cmd_load, drv_cmd_word[0]}, 16'h0002);
		wr(8'h1a, 16'h0000);
		cmp(drv_cmd_word[0], 16'h0001);
		repeat (12) @(negedge clk_sys);
		$display("t_run done");
	endtask
	task t_speed;
		wr(8'h5c, 16'hffff);
		repeat (3) @(negedge clk_sys);
		cmp(drv_speed, 16'h3000);
		wr(8'h5c, 16'h9000);
		repeat (3) @(negedge clk_sys);
		cmp(drv_speed, 16'h1000);
		$display("t_speed done");
	endtask
	task t_status;
		wr(8'h59, 16'h0040);
		wr(8'h5a, 16'h0012);
		repeat (4) @(negedge clk_sys);
		rd(8'h60);
		cmp(d, 16'h0012);
		wr(8'h59, 16'h0000);
		wr(8'h5a, 16'h0000);
		repeat (4) @(negedge clk_sys);
		rd(8'h5f);
		cmp(d, 16'h0040);
		rd(8'h00);
		cmp(d, 16'h0000);
		$display("t_status done");
	endtask
	task t_points;
		wr(8'h16, 16'h0001);
		repeat (2) @(negedge clk_sys);
		cmp({dir_fwd, dir_rev}, 16'h0001);
		wr(8'h5e, 16'h0001);
		cmp(drv_cmd_word[5:3], 16'h0005);
		repeat (2) @(negedge clk_sys);
		cmp({clear_pulse, stop_pulse, start_pulse}, 16'h0004);
		rd(8'h5b);
		cmp(d, 16'h1234);
		rd(8'h5c);
		cmp(d, 16'h1000);
		ce = 1'h0;
		wr(8'h5a, 16'h0080);
		repeat (2) @(negedge clk_sys);
		cmp({drv_cmd_load, drv_cmd_word[15]}, 16'h0000);
		ce = 1'h1;
		@(negedge clk_sys);
		nrst = 1'h0;
		repeat (2) @(negedge clk_sys);
		nrst = 1'h1;
		cmp(drv_cmd_word, 16'h0000);
		cmp({dir_fwd, dir_rev}, 16'h0000);
		$display("t_points done");
	endtask

	initial begin
		repeat (16) @(negedge clk_sys);
		nrst = 1'h1;
		cmp(drv_cmd_word, 16'h0000);
		t_word;
		t_fields;
		t_edges;
		t_run;
		t_speed;
		t_status;
		t_points;
		report_and_stop;
	end
endmodule // dcwa_top_bench
